/* dv/ctl_model.sv */
// controller-side lane model: drives write data, sees read data
// assumes the bench never drives while the device drives
`timescale 1ns/10ps

module ctl_model (
    // clock
    input wire logic i_ref_clk,
    // controller drive
    input wire logic i_drive,
    input wire sram_pkg::lane_type i_value,
    // device drive
    input wire logic i_data_oe,
    input wire logic i_parity_oe,
    input wire sram_pkg::lane_type i_dut_lane,
    // resolved lanes
    output sram_pkg::lane_type o_lane
);
    import sram_pkg::*;
    // released lanes show a pattern that flips every cycle
    lane_type junk_reg = 36'h5a5a5a5a5;
    always_ff @(posedge i_ref_clk)
    begin
        junk_reg <= ~junk_reg;
    end
    assign o_lane.data = i_drive ? i_value.data :
        i_data_oe ? i_dut_lane.data : junk_reg.data;
    assign o_lane.parity = i_drive ? i_value.parity :
        i_parity_oe ? i_dut_lane.parity : junk_reg.parity;
endmodule : ctl_model

/* dv/sram_pins_test.sv */
// self-checking bench for the pin-level memory core
// assumes the core and package compiled first; all stimulus on falling edge
`timescale 1ns/10ps

module sram_pins_test;
    import sram_pkg::*;
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; \
    $display("mismatch %0t %h %h", $time, a, b); end end
    logic i_ref_clk = 0, i_rst = 1, qn = 0, oe_n = 0, mode = 1, slp = 0;
    logic tck = 0, tms = 0, tdi = 0, drv = 0, hi;
    logic doe, poe, sa, tdo, tdoe;
    ctrl_type ctrl = 9'h16f;
    logic [5:0] addr = 6'h00;
    lane_type wval = '0, lin, lout;
    int failures = 0, checks = 0;

    sram_pins dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
        .i_clock_qualify_n(qn), .i_ctrl(ctrl), .i_addr(addr),
        .i_oe_n(oe_n), .i_lane(lin), .o_lane(lout), .o_data_oe(doe),
        .o_parity_oe(poe), .i_burst_mode(mode), .i_sleep_request(slp),
        .o_sleep_active(sa), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
        .o_tdo(tdo), .o_tdo_oe(tdoe));
    ctl_model far (.i_ref_clk(i_ref_clk), .i_drive(drv), .i_value(wval),
        .i_data_oe(doe), .i_parity_oe(poe), .i_dut_lane(lout),
        .o_lane(lin));

    initial
    begin
        forever #5 i_ref_clk = ~i_ref_clk;
    end

    // -----------------------------------------------------------------
    // bus helpers
    // -----------------------------------------------------------------
    task close_out;
        if (failures == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : close_out

    task rst_dut(input logic m);
        @(negedge i_ref_clk);
        mode = m;
        i_rst = 1;
        @(negedge i_ref_clk);
        i_rst = 0;
    endtask : rst_dut

    task op(input logic s, w, adv, input logic [3:0] bw,
        input logic [5:0] a, input lane_type d, input logic dr);
        @(negedge i_ref_clk);
        ctrl = '{!s, s, !s, w, adv, bw};
        addr = a;
        wval = d;
        drv = dr;
        @(posedge i_ref_clk);
        #1;
    endtask : op

    task rd(input logic [5:0] a, input lane_type e);
        op(1, 1, 0, 4'hf, a, '0, 0);
        op(0, 1, 1, 4'hf, 6'h00, '0, 0);
        `CHK(lout, e)
        `CHK(doe, 1'b1)
    endtask : rd

    task wr(input logic [5:0] a, input lane_type d, input logic [3:0] bw);
        op(1, 0, 0, bw, a, '0, 0);
        op(0, 1, 0, 4'hf, 6'h00, '0, 0);
        `CHK(doe, 1'b0)
        `CHK(poe, 1'b0)
        op(0, 1, 0, 4'hf, 6'h00, d, 1);
        `CHK(doe, 1'b0)
    endtask : wr

    // -----------------------------------------------------------------
    // scenarios
    // -----------------------------------------------------------------
    task t_bytes;
        op(1, 1, 0, 4'hf, 6'h05, '0, 0);
        wr(6'h05, {4'hf, 32'h11223344}, 4'h0);
        wr(6'h05, {4'h0, 32'haabbccdd}, 4'ha);
        rd(6'h05, {4'ha, 32'h11bb33dd});
    endtask : t_bytes

    task t_oe;
        @(negedge i_ref_clk);
        oe_n = 1;
        op(1, 1, 0, 4'hf, 6'h05, '0, 0);
        op(0, 1, 0, 4'hf, 6'h00, '0, 0);
        `CHK(doe, 1'b0)
        `CHK(poe, 1'b0)
        @(negedge i_ref_clk);
        oe_n = 0;
        #1;
        `CHK(poe, 1'b1)
        `CHK(lout, 36'ha11bb33dd)
    endtask : t_oe

    task t_stall;
        rd(6'h05, {4'ha, 32'h11bb33dd});
        @(negedge i_ref_clk);
        qn = 1;
        repeat (3)
        begin
            op(0, 0, 0, 4'h0, 6'h00, '0, 0);
            `CHK(lout, 36'ha11bb33dd)
            `CHK(doe, 1'b1)
        end
        @(negedge i_ref_clk);
        qn = 0;
        rd(6'h05, {4'ha, 32'h11bb33dd});
        repeat (2) op(0, 1, 0, 4'hf, 6'h00, '0, 0);
        `CHK(doe, 1'b0)
        @(negedge i_ref_clk);
        qn = 1;
        op(0, 1, 0, 4'hf, 6'h00, '0, 0);
        `CHK(doe, 1'b0)
        @(negedge i_ref_clk);
        qn = 0;
    endtask : t_stall

    task t_sleep;
        @(negedge i_ref_clk);
        slp = 1;
        repeat (4) op(1, 1, 0, 4'hf, 6'h05, '0, 0);
        `CHK(sa, 1'b1)
        `CHK(doe, 1'b0)
        @(negedge i_ref_clk);
        slp = 0;
        repeat (4) op(0, 1, 0, 4'hf, 6'h00, '0, 0);
        `CHK(sa, 1'b0)
        rd(6'h05, {4'ha, 32'h11bb33dd});
    endtask : t_sleep

    task tk(input logic m, d);
        @(negedge i_ref_clk);
        tms = m;
        tdi = d;
        tck = 1;
        repeat (3) @(posedge i_ref_clk);
        #1 hi = tdo;
        @(negedge i_ref_clk);
        tck = 0;
        repeat (3) @(posedge i_ref_clk);
        #1;
    endtask : tk

    task t_scan;
        logic [4:0] p;
        p = 5'h0d;
        repeat (5) tk(1, 0);
        tk(0, 0);
        tk(1, 0);
        tk(0, 0);
        tk(0, 0);
        `CHK(tdoe, 1'b1)
        for (int j = 0; j < 5; j++)
        begin
            tk(0, p[j]);
            `CHK(tdo, p[j])
            if (j > 0)
                `CHK(hi, p[j-1])
        end
    endtask : t_scan

    task t_burst(input logic m);
        int e;
        rst_dut(m);
        for (int i = 0; i < 4; i++)
            wr(6'(8 + i), {4'h0, 32'(i)}, 4'h0);
        rd(6'h09, {4'h0, 32'h00000001});
        for (int k = 1; k < 4; k++)
        begin
            op(0, 1, 1, 4'hf, 6'h00, '0, 0);
            e = m ? (1 ^ k) : ((1 + k) & 3);
            `CHK(lout.data, 32'(e))
        end
    endtask : t_burst

    initial
    begin
        rst_dut(1);
        for (int i = 0; i < 64; i++)
            wr(6'(i), '0, 4'h0);
        t_bytes;
        t_oe;
        t_stall;
        t_sleep;
        t_scan;
        t_burst(1);
        t_burst(0);
        close_out;
    end

    initial
    begin
        #100000;
        failures++;
        close_out;
    end
endmodule : sram_pins_test

/* inc/sram_pkg.sv */
// shared constants, lane and control carriers, tap states and lane helpers
// assumes a single 100 MHz reference clock and one active-high reset
//
// Behaviour
// - ignore clock edges while qualifier is high
// - held qualifier stretches cycle, never deselects
// - incoming data lanes captured on rising edge
// - read data driven one cycle after address
// - drive lanes only while output enable low
// - float lanes during every write data phase
// - float lanes first clock after deselect
// - float lanes whenever the device is deselected; code still drives a prior read in the cycle the deselect is taken
// - parity lanes behave exactly like data lanes
// - each parity lane follows its byte select
// - strap high interleaved, strap low linear
// - unconnected strap reads high, interleaved
// - scan output changes on test clock fall
// - scan input sampled on test clock rise
// - mode select sampled on rise, steers tap
// - sleep input high enters sleep, keeps contents
// - sleep held low normally, pulled down inside
// - advance high counts burst, low loads address
// - burst uses two low bits and wraps
package sram_pkg;

    // -----------------------------------------------------------------
    // widths, reset values and timing counts
    // -----------------------------------------------------------------
    localparam int DATA_W = 32;
    localparam int LANES = 4;
    localparam int BYTE_W = 8;
    localparam int BURST_W = 2;
    localparam logic BURST_MODE_RESET = 1'b1;
    localparam logic [3:0] BYTE_SELECT_RESET = 4'hf;
    localparam int SLEEP_CYCLES = 2;
    localparam int SLEEP_CNT_W = 2;
    localparam int IR_W = 2;
    localparam logic [1:0] IR_RESET = 2'h1;

    // -----------------------------------------------------------------
    // carriers
    // -----------------------------------------------------------------
    typedef struct packed {
        logic [LANES-1:0] parity;
        logic [DATA_W-1:0] data;
    } lane_type;

    typedef struct packed {
        logic ce1_n;
        logic ce2;
        logic ce3_n;
        logic we_n;
        logic advance_or_load;
        logic [LANES-1:0] byte_write_select_n;
    } ctrl_type;

    typedef enum logic [15:0] {
        TAP_RESET = 16'h0001, TAP_IDLE = 16'h0002,
        TAP_SEL_DR = 16'h0004, TAP_CAP_DR = 16'h0008,
        TAP_SHIFT_DR = 16'h0010, TAP_EXIT1_DR = 16'h0020,
        TAP_PAUSE_DR = 16'h0040, TAP_EXIT2_DR = 16'h0080,
        TAP_UPD_DR = 16'h0100, TAP_SEL_IR = 16'h0200,
        TAP_CAP_IR = 16'h0400, TAP_SHIFT_IR = 16'h0800,
        TAP_EXIT1_IR = 16'h1000, TAP_PAUSE_IR = 16'h2000,
        TAP_EXIT2_IR = 16'h4000, TAP_UPD_IR = 16'h8000
    } tap_state_type;

    // -----------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------
    // merge new lanes over old where the active-low byte select is low
    function automatic lane_type lane_merge(input lane_type old_lane,
        input lane_type new_lane, input logic [LANES-1:0] bw_n);
        lane_type m;
        m = old_lane;
        for (int i = 0; i < LANES; i++)
        begin
            if (!bw_n[i])
            begin
                m.data[i*BYTE_W +: BYTE_W] = new_lane.data[i*BYTE_W +: BYTE_W];
                m.parity[i] = new_lane.parity[i];
            end
        end
        return m;
    endfunction : lane_merge

endpackage : sram_pkg

/* src/burst_counter.sv */
// burst address counter over the two lowest address bits
// assumes load and advance are already qualified by the clock enable
`timescale 1ns/10ps

module burst_counter #(
    parameter int ADDR_W = 6
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // control
    input wire logic i_load,
    input wire logic i_advance,
    input wire logic i_interleave,
    input wire logic [ADDR_W-1:0] i_addr,
    // current access address
    output logic [ADDR_W-1:0] o_addr
);
    import sram_pkg::*;

    logic [ADDR_W-1:0] base_reg;
    logic [BURST_W-1:0] count_reg;
    logic [BURST_W-1:0] low_bits;

    if (ADDR_W <= BURST_W)
    begin : g_bad_addr_w
        $error("ADDR_W must exceed the burst field width");
    end

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            base_reg <= '0;
            count_reg <= '0;
        end
        else if (i_load)
        begin
            base_reg <= i_addr;
            count_reg <= '0;
        end
        else if (i_advance)
            count_reg <= count_reg + 2'h1;
    end

    // interleaved xors the count in, linear adds and wraps in the group
    assign low_bits = i_interleave ? (base_reg[BURST_W-1:0] ^ count_reg)
        : (base_reg[BURST_W-1:0] + count_reg);
    assign o_addr = {base_reg[ADDR_W-1:BURST_W], low_bits};

    a_burst_step: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        (i_advance && !i_load) |=> count_reg == $past(count_reg) + 2'h1)
        else $error("burst count did not step by one");

endmodule : burst_counter

/* src/scan_port.sv */
// boundary-scan access port with instruction and bypass registers
// assumes the test clock is sampled as an ordinary synchronous input
`timescale 1ns/10ps

module scan_port (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // scan pins
    input wire logic i_tck,
    input wire logic i_tms,
    input wire logic i_tdi,
    output logic o_tdo,
    output logic o_tdo_oe
);
    import sram_pkg::*;

    logic tck_reg;
    logic tck_rise;
    logic tck_fall;
    logic bypass_reg;
    logic [IR_W-1:0] ir_shift_reg;
    logic [IR_W-1:0] ir_reg;
    tap_state_type state_reg;
    tap_state_type state_next;

    assign tck_rise = i_tck && !tck_reg;
    assign tck_fall = !i_tck && tck_reg;

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            tck_reg <= 1'b0;
        else
            tck_reg <= i_tck;
    end

    always_comb
    begin
        case (state_reg)
            TAP_RESET: state_next = i_tms ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: state_next = i_tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: state_next = i_tms ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: state_next = i_tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: state_next = i_tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: state_next = i_tms ? TAP_UPD_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR: state_next = i_tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: state_next = i_tms ? TAP_UPD_DR : TAP_SHIFT_DR;
            TAP_UPD_DR: state_next = i_tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: state_next = i_tms ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR: state_next = i_tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: state_next = i_tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: state_next = i_tms ? TAP_UPD_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR: state_next = i_tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: state_next = i_tms ? TAP_UPD_IR : TAP_SHIFT_IR;
            TAP_UPD_IR: state_next = i_tms ? TAP_SEL_DR : TAP_IDLE;
            default: state_next = TAP_RESET;
        endcase
    end

    // state, shift registers and instruction move on test clock rise
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_reg <= TAP_RESET;
            bypass_reg <= 1'b0;
            ir_shift_reg <= '0;
            ir_reg <= IR_RESET;
        end
        else if (tck_rise)
        begin
            state_reg <= state_next;
            if (state_reg == TAP_SHIFT_DR)
                bypass_reg <= i_tdi;
            else if (state_reg == TAP_CAP_DR)
                bypass_reg <= 1'b0;
            if (state_reg == TAP_SHIFT_IR)
                ir_shift_reg <= {i_tdi, ir_shift_reg[IR_W-1:1]};
            else if (state_reg == TAP_CAP_IR)
                ir_shift_reg <= IR_RESET;
            if (state_reg == TAP_UPD_IR)
                ir_reg <= ir_shift_reg;
            else if (state_reg == TAP_RESET)
                ir_reg <= IR_RESET;
        end
    end

    // every instruction selects bypass; output launched on the fall
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_tdo <= 1'b0;
            o_tdo_oe <= 1'b0;
        end
        else if (tck_fall)
        begin
            o_tdo <= (state_reg == TAP_SHIFT_IR) ? ir_shift_reg[0]
                : bypass_reg;
            o_tdo_oe <= (state_reg == TAP_SHIFT_IR)
                || (state_reg == TAP_SHIFT_DR);
        end
    end

    a_tdo_on_fall: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        !tck_fall |=> $stable(o_tdo))
        else $error("scan output moved without a test clock fall");

    a_tdi_on_rise: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        (tck_rise && state_reg == TAP_SHIFT_DR) |=> bypass_reg == $past(i_tdi))
        else $error("scan input not taken on test clock rise");

    a_tms_steers: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        (tck_rise && i_tms && state_reg == TAP_SHIFT_DR)
        |=> state_reg == TAP_EXIT1_DR)
        else $error("tap did not leave shift on mode select high");

endmodule : scan_port

/* src/sram_pins.sv */
// pin-level core of a pipelined burst synchronous memory
// assumes all pins synchronous to i_ref_clk; lanes and scan output split
// into input, output and output enable, resolved outside
`timescale 1ns/10ps

module sram_pins #(
    parameter int ADDR_W = 6
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // synchronous bus
    input wire logic i_clock_qualify_n,
    input wire sram_pkg::ctrl_type i_ctrl,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic i_oe_n,
    // data and parity lanes
    input wire sram_pkg::lane_type i_lane,
    output sram_pkg::lane_type o_lane,
    output logic o_data_oe,
    output logic o_parity_oe,
    // strap and sleep
    input wire logic i_burst_mode,
    input wire logic i_sleep_request,
    output logic o_sleep_active,
    // boundary scan
    input wire logic i_tck,
    input wire logic i_tms,
    input wire logic i_tdi,
    output logic o_tdo,
    output logic o_tdo_oe
);
    import sram_pkg::*;

    localparam int DEPTH = 1 << ADDR_W;

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);

    if (ADDR_W < BURST_W + 1 || ADDR_W > 16)
    begin : g_bad_addr_w
        $error("ADDR_W must lie between 3 and 16");
    end

    // -----------------------------------------------------------------
    // declarations
    // -----------------------------------------------------------------
    logic en;
    logic load;
    logic selected;
    logic mode_reg;
    logic strap_taken_reg;
    logic [SLEEP_CNT_W-1:0] sleep_cnt_reg;
    logic sleep_active_reg;
    logic s1_valid_reg;
    logic s1_write_reg;
    logic [LANES-1:0] s1_bw_reg;
    logic [ADDR_W-1:0] s1_addr;
    logic s2_write_reg;
    logic [ADDR_W-1:0] s2_addr_reg;
    logic [LANES-1:0] s2_bw_reg;
    logic drive_reg;
    lane_type out_reg;
    lane_type read_next;
    lane_type mem_reg [DEPTH];
    logic lane_oe;

    // -----------------------------------------------------------------
    // clock qualification
    // -----------------------------------------------------------------
    // a masked edge freezes every pipeline stage; nothing is deselected
    assign en = !i_clock_qualify_n && !sleep_active_reg;

    assign load = !i_ctrl.advance_or_load;
    assign selected = !i_ctrl.ce1_n && i_ctrl.ce2 && !i_ctrl.ce3_n;

    // -----------------------------------------------------------------
    // burst order strap
    // -----------------------------------------------------------------
    // the pad pull-up makes an open strap read high; taken once after
    // reset release so a later change cannot disturb a running burst
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            mode_reg <= BURST_MODE_RESET;
            strap_taken_reg <= 1'b0;
        end
        else if (!strap_taken_reg)
        begin
            mode_reg <= i_burst_mode;
            strap_taken_reg <= 1'b1;
        end
    end

    // -----------------------------------------------------------------
    // sleep entry and exit
    // -----------------------------------------------------------------
    // a low request is normal operation; the pad pull-down covers an
    // open pin, so only a driven high level counts toward sleep
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            sleep_cnt_reg <= '0;
        else if (i_sleep_request)
        begin
            if (sleep_cnt_reg != SLEEP_CNT_W'(SLEEP_CYCLES))
                sleep_cnt_reg <= sleep_cnt_reg + 2'h1;
        end
        else if (sleep_cnt_reg != '0)
            sleep_cnt_reg <= sleep_cnt_reg - 2'h1;
    end

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            sleep_active_reg <= 1'b0;
        else if (i_sleep_request
            && sleep_cnt_reg == SLEEP_CNT_W'(SLEEP_CYCLES - 1))
            sleep_active_reg <= 1'b1;
        else if (!i_sleep_request && sleep_cnt_reg == SLEEP_CNT_W'(1))
            sleep_active_reg <= 1'b0;
    end

    assign o_sleep_active = sleep_active_reg;

    // -----------------------------------------------------------------
    // address stage
    // -----------------------------------------------------------------
    burst_counter #(
        .ADDR_W(ADDR_W)
    ) u_burst (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_load(en && load && selected),
        .i_advance(en && !load),
        .i_interleave(mode_reg),
        .i_addr(i_addr),
        .o_addr(s1_addr)
    );

    // a load takes select and direction; an advance keeps both so a
    // burst continues whatever the enables and write enable show
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            s1_valid_reg <= 1'b0;
            s1_write_reg <= 1'b0;
        end
        else if (en && load)
        begin
            s1_valid_reg <= selected;
            s1_write_reg <= !i_ctrl.we_n;
        end
    end

    // byte selects belong to every cycle of a burst write
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            s1_bw_reg <= BYTE_SELECT_RESET;
        else if (en)
            s1_bw_reg <= i_ctrl.byte_write_select_n;
    end

    // -----------------------------------------------------------------
    // data stage
    // -----------------------------------------------------------------
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            s2_write_reg <= 1'b0;
            s2_addr_reg <= '0;
            s2_bw_reg <= BYTE_SELECT_RESET;
        end
        else if (en)
        begin
            s2_write_reg <= s1_valid_reg && s1_write_reg;
            s2_addr_reg <= s1_addr;
            s2_bw_reg <= s1_bw_reg;
        end
    end

    // a read right behind a write to the same word sees the new bytes
    always_comb
    begin
        read_next = mem_reg[s1_addr];
        if (s2_write_reg && s2_addr_reg == s1_addr)
            read_next = lane_merge(read_next, i_lane, s2_bw_reg);
    end

    // drive only in the cycle after a read address; a write, a deselect
    // or the first cycle out of a deselect leaves the lanes floating
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            drive_reg <= 1'b0;
            out_reg <= '0;
        end
        else if (en)
        begin
            drive_reg <= s1_valid_reg && !s1_write_reg;
            if (s1_valid_reg && !s1_write_reg)
                out_reg <= read_next;
        end
    end

    // -----------------------------------------------------------------
    // storage
    // -----------------------------------------------------------------
    // write data and parity are taken straight off the lanes at the
    // edge that closes the data phase, each byte under its own select
    always_ff @(posedge i_ref_clk)
    begin
        if (en && s2_write_reg)
            mem_reg[s2_addr_reg] <= lane_merge(mem_reg[s2_addr_reg], i_lane,
                s2_bw_reg);
    end

    // -----------------------------------------------------------------
    // lane direction
    // -----------------------------------------------------------------
    assign lane_oe = drive_reg && !i_oe_n && !sleep_active_reg;
    assign o_data_oe = lane_oe;
    assign o_parity_oe = lane_oe;
    assign o_lane = out_reg;

    // -----------------------------------------------------------------
    // boundary scan
    // -----------------------------------------------------------------
    scan_port u_scan (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_tck(i_tck),
        .i_tms(i_tms),
        .i_tdi(i_tdi),
        .o_tdo(o_tdo),
        .o_tdo_oe(o_tdo_oe)
    );

    // -----------------------------------------------------------------
    // assertions
    // -----------------------------------------------------------------
    sequence read_issue;
        en && s1_valid_reg && !s1_write_reg;
    endsequence

    sequence write_issue;
        en && s1_valid_reg && s1_write_reg;
    endsequence

    sequence desel_then_masked;
        en && !s1_valid_reg ##1 !en;
    endsequence

    a_masked_hold: assert property (
        !en |=> $stable(drive_reg) && $stable(out_reg))
        else $error("masked edge changed output stage");

    a_qualify_keeps: assert property (
        i_clock_qualify_n |=> $stable(s1_valid_reg) && $stable(s1_write_reg))
        else $error("held qualifier changed the access state");

    a_read_latency: assert property (
        read_issue |=> drive_reg && out_reg == $past(read_next))
        else $error("read data not presented one cycle later");

    a_oe_gates: assert property (
        i_oe_n |-> !o_data_oe && !o_parity_oe)
        else $error("lanes driven while output enable high");

    a_write_float: assert property (
        write_issue |=> !o_data_oe)
        else $error("lanes driven in a write data phase");

    a_desel_float: assert property (
        desel_then_masked |-> !o_data_oe)
        else $error("lanes driven after a deselect");

    a_parity_same: assert property (
        o_parity_oe == o_data_oe)
        else $error("parity lane direction differs from data");

    a_write_store: assert property (
        (en && s2_write_reg) |=> mem_reg[$past(s2_addr_reg)]
        == lane_merge($past(mem_reg[s2_addr_reg]), $past(i_lane),
        $past(s2_bw_reg)))
        else $error("write lanes not stored under byte selects");

    a_sleep_entry: assert property (
        i_sleep_request [*2] |=> o_sleep_active)
        else $error("sleep not entered after two request cycles");

    a_sleep_float: assert property (
        o_sleep_active |-> !o_data_oe && !en)
        else $error("activity or drive during sleep");

    a_strap_fixed: assert property (
        strap_taken_reg |=> $stable(mode_reg))
        else $error("burst order changed during operation");

endmodule : sram_pins
